// File: hw/rsa_pkg.sv
// Constants and types for the serial access and time trimming engine
package rsa_pkg;
    // Two-wire bus identity and pointer handling
    localparam logic [6:0] SLV_ADDR = 7'h32;
    localparam logic [3:0] PTR_IDLE = 4'hF;
    localparam logic [3:0] FMT_WRITE = 4'h0;
    localparam logic [3:0] FMT_QUICK_RD = 4'h4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // Clocks and time figures
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int OSC_HZ_NOM = 32768;
    localparam int TRIM_PERIOD_S = 20;
    localparam int TRIM_STEP = 2;
    localparam int TIMEOUT_MS = 750;
    localparam int CARRY_LIMIT_US = 61;
    localparam int CARRY_LIMIT_CYC = CARRY_LIMIT_US * (SYS_CLK_HZ / 1_000_000);
    localparam int CARRY_USED_CYC = 1;

    // Control port map
    localparam logic [1:0] CTL_TRIM = 2'h0;
    localparam logic [1:0] CTL_STAT = 2'h1;
    localparam logic [6:0] TRIM_RST = 7'h00;
    localparam int STAT_HOLD = 7;
    localparam int STAT_ABORT = 6;
    localparam int STAT_PEND = 5;
    localparam int STAT_HALT = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK
    } rsa_state_t;
endpackage : rsa_pkg

// File: hw/rsa_serial_trim.sv
// Two-wire slave access engine with counter hold, bus watchdog and time trimming
//
// Behaviour
// - Any stop condition reloads the address pointer with Fh.
// - Format nibble 4h switches to sending data right after that byte.
// - Read right after address byte starts at current pointer, normally Fh.
// - Time counters are held from start until the following stop.
// - A seconds carry caught during hold is applied within 61 us of stop.
// - After 0.5 to 1.0 s the access is aborted as if stopped.
// - Repeated start does not restart the access watchdog.
// - After abort, writes get no acknowledge and reads return FFh.
// - Trimming alters the pulse count of one second in every twenty.
// - No correction when the middle five trim bits are all zero.
// - While the oscillator-halt flag is set the second interrupt pin carries the oscillator.
// - First written byte holds 4-bit pointer and 4-bit format nibble.
// - Pointer advances by one per data byte, wrapping Fh to 0h.
// - The slave answers the seven-bit address 0110010.
// - Trim field is a seven-bit two's complement pulse-count adjustment.
module rsa_serial_trim #(
    parameter int OSC_PER_SEC = rsa_pkg::OSC_HZ_NOM,
    parameter int TIMEOUT_EDGES = rsa_pkg::OSC_HZ_NOM * rsa_pkg::TIMEOUT_MS / 1000
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Oscillator and halt flag
    input wire logic osc_clk_i,
    input wire logic osc_halt_flag_i,
    output logic second_irq_pin_o,
    output logic second_irq_pin_oe_o,
    // Internal register file
    output logic [3:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic mem_we_o,
    output logic mem_re_o,
    input wire logic [7:0] mem_rdata_i,
    // Time counter side
    output logic sec_carry_o,
    output logic counters_hold_o,
    // Control port
    input wire logic [1:0] ctl_addr_i,
    input wire logic [7:0] ctl_wdata_i,
    input wire logic ctl_we_i,
    input wire logic ctl_re_i,
    output logic [7:0] ctl_rdata_o
);
    // A second must stay longer than the deepest trim cut of 124 edges
    if (OSC_PER_SEC < 128 || OSC_PER_SEC > 65535) begin : g_bad_osc
        $error("OSC_PER_SEC out of range");
    end
    if (TIMEOUT_EDGES < 2 || TIMEOUT_EDGES > 65535) begin : g_bad_to
        $error("TIMEOUT_EDGES out of range");
    end
    if (rsa_pkg::CARRY_LIMIT_CYC < rsa_pkg::CARRY_USED_CYC) begin : g_bad_carry
        $error("Carry latency exceeds its limit");
    end

    logic [2:0] scl_sync_ff;
    logic [2:0] sda_sync_ff;
    logic [2:0] osc_sync_ff;
    logic scl_rise, scl_fall, start_det, stop_det, osc_rise, sda_s;
    rsa_pkg::rsa_state_t st_ff;
    logic [3:0] ptr_ff, fmt_ff, bitcnt_ff;
    logic [7:0] shift_ff;
    logic rw_ff, m_ack_ff, first_ff, rd_after_ff, rd_load_ff, aborted_ff, sda_oe_ff;
    logic [3:0] mem_addr_ff;
    logic [7:0] mem_wdata_ff;
    logic mem_we_ff, mem_re_ff;
    logic hold_ff, pend_ff, sec_carry_ff;
    logic [15:0] to_cnt_ff;
    logic to_fire, rd_go, sec_tick, trim_slot;
    logic [16:0] sec_cnt_ff, sec_last;
    logic [4:0] sec20_ff;
    logic [6:0] trim_ff;
    logic [7:0] ctl_rdata_ff;
    logic irq_oe_ff;

    function automatic logic [3:0] ptr_next(input logic [3:0] p);
        ptr_next = 4'(p + 4'h1);
    endfunction : ptr_next

    // pulse-count change for the trimmed second
    function automatic int trim_delta(input logic [6:0] f);
        int v;
        v = f[6] ? int'(f) - 128 : int'(f);
        if (f[5:1] == 5'h00)
            trim_delta = 0;
        else if (f[6])
            trim_delta = v * rsa_pkg::TRIM_STEP;
        else
            trim_delta = (v - 1) * rsa_pkg::TRIM_STEP;
    endfunction : trim_delta

    // Pin inputs pass two flops; bit 0 feeds only bit 1
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            osc_sync_ff <= 3'h0;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
            sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
            osc_sync_ff <= {osc_sync_ff[1:0], osc_clk_i};
        end
    end

    assign sda_s = sda_sync_ff[1];
    assign scl_rise = scl_sync_ff[1] && !scl_sync_ff[2];
    assign scl_fall = !scl_sync_ff[1] && scl_sync_ff[2];
    assign start_det = scl_sync_ff[1] && scl_sync_ff[2] && !sda_sync_ff[1] && sda_sync_ff[2];
    assign stop_det = scl_sync_ff[1] && scl_sync_ff[2] && sda_sync_ff[1] && !sda_sync_ff[2];
    assign osc_rise = osc_sync_ff[1] && !osc_sync_ff[2];

    assign rd_go = scl_fall && ((st_ff == rsa_pkg::ST_ADDR_ACK && rw_ff)
        || (st_ff == rsa_pkg::ST_WR_ACK && rd_after_ff)
        || (st_ff == rsa_pkg::ST_RD_ACK && m_ack_ff));

    // Bus engine: pointer, format and bit handling
    always_ff @(posedge clk_sys_i)
    begin
        mem_we_ff <= 1'b0;
        mem_re_ff <= 1'b0;
        rd_load_ff <= mem_re_ff;
        if (!rst_n_i)
        begin
            st_ff <= rsa_pkg::ST_IDLE;
            ptr_ff <= rsa_pkg::PTR_IDLE;
            fmt_ff <= rsa_pkg::FMT_WRITE;
            bitcnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            rw_ff <= 1'b0;
            m_ack_ff <= 1'b0;
            first_ff <= 1'b0;
            rd_after_ff <= 1'b0;
            aborted_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            mem_addr_ff <= 4'h0;
            mem_wdata_ff <= 8'h00;
            rd_load_ff <= 1'b0;
        end
        else if (stop_det || to_fire)
        begin
            st_ff <= rsa_pkg::ST_IDLE;
            ptr_ff <= rsa_pkg::PTR_IDLE;
            fmt_ff <= rsa_pkg::FMT_WRITE;
            rd_after_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            aborted_ff <= to_fire;
        end
        else if (start_det)
        begin
            st_ff <= aborted_ff ? rsa_pkg::ST_IDLE : rsa_pkg::ST_ADDR;
            bitcnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
        end
        else if (rd_go)
        begin
            st_ff <= rsa_pkg::ST_RD;
            mem_re_ff <= 1'b1;
            mem_addr_ff <= ptr_ff;
            ptr_ff <= ptr_next(ptr_ff);
            bitcnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
        end
        else
        begin
            case (st_ff)
                rsa_pkg::ST_ADDR:
                    if (scl_rise)
                    begin
                        shift_ff <= {shift_ff[6:0], sda_s};
                        bitcnt_ff <= 4'(bitcnt_ff + 4'h1);
                    end
                    else if (scl_fall && bitcnt_ff == rsa_pkg::BITS_PER_BYTE)
                    begin
                        if (shift_ff[7:1] == rsa_pkg::SLV_ADDR)
                        begin
                            st_ff <= rsa_pkg::ST_ADDR_ACK;
                            sda_oe_ff <= 1'b1;
                            rw_ff <= shift_ff[0];
                            first_ff <= 1'b1;
                        end
                        else
                            st_ff <= rsa_pkg::ST_IDLE;
                    end
                rsa_pkg::ST_ADDR_ACK, rsa_pkg::ST_WR_ACK:
                    if (scl_fall)
                    begin
                        st_ff <= rsa_pkg::ST_WR;
                        sda_oe_ff <= 1'b0;
                        bitcnt_ff <= 4'h0;
                    end
                rsa_pkg::ST_WR:
                    if (scl_rise)
                    begin
                        shift_ff <= {shift_ff[6:0], sda_s};
                        bitcnt_ff <= 4'(bitcnt_ff + 4'h1);
                    end
                    else if (scl_fall && bitcnt_ff == rsa_pkg::BITS_PER_BYTE)
                    begin
                        st_ff <= rsa_pkg::ST_WR_ACK;
                        sda_oe_ff <= 1'b1;
                        first_ff <= 1'b0;
                        if (first_ff)
                        begin
                            ptr_ff <= shift_ff[7:4];
                            fmt_ff <= shift_ff[3:0];
                            rd_after_ff <= (shift_ff[3:0] == rsa_pkg::FMT_QUICK_RD);
                        end
                        else
                        begin
                            mem_we_ff <= 1'b1;
                            mem_addr_ff <= ptr_ff;
                            mem_wdata_ff <= shift_ff;
                            ptr_ff <= ptr_next(ptr_ff);
                        end
                    end
                rsa_pkg::ST_RD:
                    if (rd_load_ff)
                    begin
                        shift_ff <= mem_rdata_i;
                        sda_oe_ff <= !mem_rdata_i[7];
                    end
                    else if (scl_fall)
                    begin
                        if (bitcnt_ff == rsa_pkg::LAST_BIT)
                        begin
                            st_ff <= rsa_pkg::ST_RD_ACK;
                            sda_oe_ff <= 1'b0;
                        end
                        else
                        begin
                            shift_ff <= {shift_ff[6:0], 1'b1};
                            sda_oe_ff <= !shift_ff[6];
                            bitcnt_ff <= 4'(bitcnt_ff + 4'h1);
                        end
                    end
                rsa_pkg::ST_RD_ACK:
                    if (scl_rise)
                        m_ack_ff <= !sda_s;
                    else if (scl_fall)
                        st_ff <= rsa_pkg::ST_IDLE;
                default:
                    st_ff <= rsa_pkg::ST_IDLE;
            endcase
        end
    end

    // hold and watchdog, the count clears while hold is low, so a repeated start keeps it
    assign to_fire = hold_ff && (to_cnt_ff == 16'(TIMEOUT_EDGES));
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            hold_ff <= 1'b0;
            to_cnt_ff <= 16'h0000;
        end
        else
        begin
            if (stop_det || to_fire)
                hold_ff <= 1'b0;
            else if (start_det && !aborted_ff)
                hold_ff <= 1'b1;
            if (!hold_ff)
                to_cnt_ff <= 16'h0000;
            else if (osc_rise && !to_fire)
                to_cnt_ff <= 16'(to_cnt_ff + 16'h0001);
        end
    end

    // one trimmed second in every twenty
    assign trim_slot = (sec20_ff == 5'h00);
    assign sec_last = 17'(OSC_PER_SEC - 1 + (trim_slot ? trim_delta(trim_ff) : 0));
    assign sec_tick = osc_rise && (sec_cnt_ff >= sec_last);
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            sec_cnt_ff <= 17'h00000;
            sec20_ff <= 5'h00;
        end
        else if (sec_tick)
        begin
            sec_cnt_ff <= 17'h00000;
            sec20_ff <= (sec20_ff == 5'(rsa_pkg::TRIM_PERIOD_S - 1)) ? 5'h00 : 5'(sec20_ff + 5'h01);
        end
        else if (osc_rise)
            sec_cnt_ff <= 17'(sec_cnt_ff + 17'h00001);
    end

    // one pending carry, released one cycle after hold drops
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            pend_ff <= 1'b0;
            sec_carry_ff <= 1'b0;
        end
        else
        begin
            sec_carry_ff <= !hold_ff && (pend_ff || sec_tick);
            if (sec_tick && (hold_ff || pend_ff))
                pend_ff <= 1'b1;
            else if (!hold_ff)
                pend_ff <= 1'b0;
        end
    end

    // open-drain copy of the oscillator while halt flag is set
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            irq_oe_ff <= 1'b0;
        else
            irq_oe_ff <= osc_halt_flag_i && !osc_sync_ff[2];
    end

    // Control port; unmapped reads return zero
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            trim_ff <= rsa_pkg::TRIM_RST;
            ctl_rdata_ff <= 8'h00;
        end
        else
        begin
            if (ctl_we_i && ctl_addr_i == rsa_pkg::CTL_TRIM)
                trim_ff <= ctl_wdata_i[6:0];
            ctl_rdata_ff <= 8'h00;
            if (ctl_re_i && ctl_addr_i == rsa_pkg::CTL_TRIM)
                ctl_rdata_ff <= {1'b0, trim_ff};
            else if (ctl_re_i && ctl_addr_i == rsa_pkg::CTL_STAT)
            begin
                ctl_rdata_ff[rsa_pkg::STAT_HOLD] <= hold_ff;
                ctl_rdata_ff[rsa_pkg::STAT_ABORT] <= aborted_ff;
                ctl_rdata_ff[rsa_pkg::STAT_PEND] <= pend_ff;
                ctl_rdata_ff[rsa_pkg::STAT_HALT] <= osc_halt_flag_i;
                ctl_rdata_ff[3:0] <= ptr_ff;
            end
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_ff;
    assign second_irq_pin_o = 1'b0;
    assign second_irq_pin_oe_o = irq_oe_ff;
    assign mem_addr_o = mem_addr_ff;
    assign mem_wdata_o = mem_wdata_ff;
    assign mem_we_o = mem_we_ff;
    assign mem_re_o = mem_re_ff;
    assign sec_carry_o = sec_carry_ff;
    assign counters_hold_o = hold_ff;
    assign ctl_rdata_o = ctl_rdata_ff;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_hold_release;
        hold_ff ##1 !hold_ff;
    endsequence

    chk_stop_ptr_reload: assert property (stop_det |=> ptr_ff == rsa_pkg::PTR_IDLE)
        else $error("pointer not Fh after stop");
    chk_quick_read: assert property (st_ff == rsa_pkg::ST_WR_ACK && rd_after_ff && scl_fall && !stop_det && !to_fire
        && !start_det |=> st_ff == rsa_pkg::ST_RD ##1 mem_re_o == 1'b0)
        else $error("format 4 did not switch to sending");
    chk_hold_start: assert property (start_det && !aborted_ff && !stop_det && !to_fire |=> hold_ff)
        else $error("counters not held after start");
    chk_carry_release: assert property (s_hold_release ##0 pend_ff |=> sec_carry_o)
        else $error("held carry not applied after release");
    chk_timeout_abort: assert property (to_fire |=> !hold_ff && aborted_ff && ptr_ff == rsa_pkg::PTR_IDLE)
        else $error("watchdog did not abort access");
    chk_rstart_keep: assert property (start_det && hold_ff && !to_fire |=> to_cnt_ff >= $past(to_cnt_ff))
        else $error("repeated start restarted watchdog");
    chk_abort_silent: assert property (aborted_ff && $past(aborted_ff) |-> !sda_oe_o)
        else $error("bus driven after abort");
    chk_ptr_advance: assert property (mem_we_o || mem_re_o |-> ptr_ff == ptr_next(mem_addr_o))
        else $error("pointer did not advance by one");
    chk_addr_match: assert property ($rose(st_ff == rsa_pkg::ST_ADDR_ACK) |-> shift_ff[7:1] == rsa_pkg::SLV_ADDR
        && sda_oe_o)
        else $error("acknowledged a foreign address");
    chk_trim_off: assert property (osc_rise && trim_ff[5:1] == 5'h00
        && sec_cnt_ff == 17'(OSC_PER_SEC - 1) |-> sec_tick)
        else $error("correction applied with middle bits zero");
    chk_plain_second: assert property (osc_rise && !trim_slot
        && sec_cnt_ff == 17'(OSC_PER_SEC - 1) |-> sec_tick)
        else $error("untrimmed second has wrong length");
    chk_osc_copy: assert property (osc_halt_flag_i && $fell(osc_sync_ff[2]) |=> second_irq_pin_oe_o)
        else $error("oscillator not copied to pin");
endmodule : rsa_serial_trim

// File: dv/rsa_i2c_master.sv
// Two-wire bus master model that drives the block's bus pins
module rsa_i2c_master (
    // Bus pins
    output logic scl_o,
    output logic sda_oe_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // Quarter of the 125 ns bus clock; SCL stands high between frames
    localparam realtime Q = 31.25;

    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    // Also serves as repeated start when SCL is low
    task automatic start();
        sda_oe_o = 1'b0;
        #Q scl_o = 1'b1;
        #(2 * Q) sda_oe_o = 1'b1;
        #(2 * Q) scl_o = 1'b0;
    endtask : start

    // Sample in mid-high, well after the slave's delayed drive
    task automatic bit_io(input logic b, output logic r);
        #Q sda_oe_o = ~b;
        #Q scl_o = 1'b1;
        #Q r = sda_i;
        #Q scl_o = 1'b0;
    endtask : bit_io

    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ack_in, r);
        ack = ~r;
    endtask : xfer

    task automatic stop();
        #Q sda_oe_o = 1'b1;
        #Q scl_o = 1'b1;
        #(2 * Q) sda_oe_o = 1'b0;
        #62000;
    endtask : stop
endmodule : rsa_i2c_master

// File: dv/test_rsa_serial_trim.sv
// Self-checking bench for the serial access and time trimming engine
module test_rsa_serial_trim;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NSEC = 130;
    localparam int NTO = 500;
    localparam int OPER = 4;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic osc_clk_i = 1'b0;
    logic osc_halt_flag_i = 1'b0;
    logic [1:0] ctl_addr_i = 2'h0;
    logic [7:0] ctl_wdata_i = 8'h00;
    logic ctl_we_i = 1'b0;
    logic ctl_re_i = 1'b0;
    logic [7:0] mem_rdata_i = 8'h00;
    logic scl_i, m_oe, sda_o, sda_oe_o, second_irq_pin_o, second_irq_pin_oe_o;
    logic [3:0] mem_addr_o;
    logic [7:0] mem_wdata_o, ctl_rdata_o, d, q, w0, w1;
    logic mem_we_o, mem_re_o, sec_carry_o, counters_hold_o, a, hold_q;
    logic [3:0] p, oh;
    logic [6:0] tf [3];
    logic [7:0] mem [16];
    int fails = 0, n_tests = 0, cyc = 0, n_held = 0, n_early = 0, t_rel = -100, t0, h0;
    wire sda_i = !(m_oe | sda_oe_o);
    wire irq_w = !second_irq_pin_oe_o;

    rsa_serial_trim #(.OSC_PER_SEC(NSEC), .TIMEOUT_EDGES(NTO)) dut_u (.clk_sys_i, .rst_n_i, .scl_i, .sda_i,
        .sda_o, .sda_oe_o, .osc_clk_i, .osc_halt_flag_i, .second_irq_pin_o, .second_irq_pin_oe_o,
        .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_re_o, .mem_rdata_i, .sec_carry_o, .counters_hold_o,
        .ctl_addr_i, .ctl_wdata_i, .ctl_we_i, .ctl_re_i, .ctl_rdata_o);
    rsa_i2c_master m_u (.scl_o(scl_i), .sda_oe_o(m_oe), .sda_i(sda_i));

    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Oscillator edges fall between clock edges, four cycles a period
    initial
    begin
        #7;
        forever #20 osc_clk_i = ~osc_clk_i;
    end

    // Register file; idle read data toggles so stale use shows up
    always @(posedge clk_sys_i)
    begin
        if (mem_we_o)
            mem[mem_addr_o] <= mem_wdata_o;
        mem_rdata_i <= mem_re_o ? mem[mem_addr_o] : ~mem_rdata_i;
    end

    always @(negedge clk_sys_i)
    begin
        cyc++;
        if (counters_hold_o === 1'b1 && sec_carry_o === 1'b1)
            n_held++;
        if (hold_q === 1'b1 && counters_hold_o === 1'b0)
        begin
            t_rel = cyc;
            n_early = 0;
        end
        if (sec_carry_o === 1'b1 && cyc - t_rel < 5)
            n_early++;
        hold_q = counters_hold_o;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic ctl_wr(input logic [1:0] ad, input logic [7:0] wd);
        @(posedge clk_sys_i);
        ctl_addr_i <= ad;
        ctl_wdata_i <= wd;
        ctl_we_i <= 1'b1;
        @(posedge clk_sys_i);
        ctl_we_i <= 1'b0;
    endtask : ctl_wr

    task automatic ctl_rd(input logic [1:0] ad);
        @(posedge clk_sys_i);
        ctl_addr_i <= ad;
        ctl_re_i <= 1'b1;
        @(posedge clk_sys_i);
        ctl_re_i <= 1'b0;
        #1 d = ctl_rdata_o;
    endtask : ctl_rd

    function automatic int exp_len(input logic [6:0] f);
        if (f[5:1] == 5'h00)
            return NSEC;
        return f[6] ? NSEC + 2 * $signed(f) : NSEC + 2 * (int'(f) - 1);
    endfunction : exp_len

    task automatic trim_case(input logic [6:0] f);
        int len;
        int odd = 0;
        int n_odd = 0;
        ctl_wr(rsa_pkg::CTL_TRIM, {1'b0, f});
        ctl_rd(rsa_pkg::CTL_TRIM);
        check(d, {1'b0, f});
        // First two spans may straddle the trim update
        for (int i = 0; i < 22; i++)
        begin
            len = 0;
            do
            begin
                @(negedge clk_sys_i);
                len++;
            end
            while (sec_carry_o !== 1'b1 && len < 2000);
            if (i > 1 && len != NSEC * OPER)
            begin
                n_odd++;
                odd = len;
            end
        end
        check(n_odd, (exp_len(f) == NSEC) ? 0 : 1);
        check(odd, (exp_len(f) == NSEC) ? 0 : exp_len(f) * OPER);
        $display("trim test %h done", f);
    endtask : trim_case

    task automatic finish_test();
        $display("comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    initial
    begin
        #1000us;
        fails++;
        finish_test();
    end

    initial
    begin
        void'($urandom(32'h6521a0a7));
        foreach (mem[i])
            mem[i] = 8'($urandom());
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        ctl_rd(rsa_pkg::CTL_TRIM);
        check(d, {1'b0, rsa_pkg::TRIM_RST});
        ctl_wr(rsa_pkg::CTL_STAT, 8'hA5);
        ctl_wr(2'h3, 8'h5A);
        ctl_rd(rsa_pkg::CTL_STAT);
        check(d, {4'h0, rsa_pkg::PTR_IDLE});
        ctl_rd(2'h3);
        check(d, 8'h00);
        check({sda_o, second_irq_pin_o}, 2'b00);
        $display("register test done");
        w0 = 8'($urandom());
        w1 = 8'($urandom());
        m_u.start();
        m_u.xfer({rsa_pkg::SLV_ADDR, 1'b0}, 1'b1, q, a);
        check(a, 1);
        m_u.xfer({rsa_pkg::PTR_IDLE, rsa_pkg::FMT_WRITE}, 1'b1, q, a);
        check(a, 1);
        m_u.xfer(w0, 1'b1, q, a);
        m_u.xfer(w1, 1'b1, q, a);
        check(counters_hold_o, 1);
        m_u.stop();
        check(mem[15], w0);
        check(mem[0], w1);
        ctl_rd(rsa_pkg::CTL_STAT);
        check(d, {4'h0, rsa_pkg::PTR_IDLE});
        $display("write test done");
        for (int m = 0; m < 3; m++)
        begin
            p = (m == 2) ? rsa_pkg::PTR_IDLE : 4'($urandom());
            m_u.start();
            if (m < 2)
            begin
                m_u.xfer({rsa_pkg::SLV_ADDR, 1'b0}, 1'b1, q, a);
                m_u.xfer({p, (m == 1) ? rsa_pkg::FMT_QUICK_RD : rsa_pkg::FMT_WRITE}, 1'b1, q, a);
                check(a, 1);
                if (m == 0)
                    m_u.start();
            end
            if (m != 1)
            begin
                m_u.xfer({rsa_pkg::SLV_ADDR, 1'b1}, 1'b1, q, a);
                check(a, 1);
            end
            for (int i = 0; i < 3; i++)
            begin
                m_u.xfer(8'hFF, i == 2, q, a);
                check(q, mem[p + 4'(i)]);
            end
            m_u.stop();
            $display("read method %0d done", m + 1);
        end
        m_u.start();
        m_u.xfer({rsa_pkg::SLV_ADDR ^ 7'(1 << $urandom_range(0, 6)), 1'b0}, 1'b1, q, a);
        check(a, 0);
        m_u.stop();
        $display("foreign address test done");
        h0 = n_held;
        m_u.start();
        m_u.xfer({rsa_pkg::SLV_ADDR, 1'b0}, 1'b1, q, a);
        m_u.xfer({4'($urandom()), rsa_pkg::FMT_WRITE}, 1'b1, q, a);
        // Over two seconds of oscillator, still short of the watchdog
        #10500;
        ctl_rd(rsa_pkg::CTL_STAT);
        check({d[rsa_pkg::STAT_HOLD], d[rsa_pkg::STAT_PEND]}, 2'b11);
        m_u.stop();
        check(n_held, h0);
        check(n_early, 1);
        $display("held carry test done");
        t0 = cyc;
        m_u.start();
        m_u.xfer({rsa_pkg::SLV_ADDR, 1'b0}, 1'b1, q, a);
        m_u.xfer({4'($urandom()), rsa_pkg::FMT_WRITE}, 1'b1, q, a);
        #6000;
        m_u.start();
        m_u.xfer({rsa_pkg::SLV_ADDR, 1'b1}, 1'b1, q, a);
        check(a, 1);
        for (int c = 0; counters_hold_o === 1'b1 && c < 3000; c++)
            @(negedge clk_sys_i);
        // Start detection and the release pipeline add a few cycles to the count
        check(cyc - t0 >= (NTO - 1) * OPER && cyc - t0 <= NTO * OPER + 40, 1);
        ctl_rd(rsa_pkg::CTL_STAT);
        check({d[7:6], d[3:0]}, {2'b01, rsa_pkg::PTR_IDLE});
        m_u.xfer(8'($urandom()), 1'b1, q, a);
        check(a, 0);
        m_u.xfer(8'hFF, 1'b1, q, a);
        check(q, 8'hFF);
        m_u.stop();
        $display("watchdog test done");
        for (int h = 0; h < 2; h++)
        begin
            @(posedge clk_sys_i);
            osc_halt_flag_i <= 1'(h);
            // Pin trails the oscillator by four cycles of sync and output flops
            for (int k = 0; k < 16; k++)
            begin
                @(negedge clk_sys_i);
                if (k > 4)
                    check(irq_w, h ? oh[3] : 1'b1);
                oh = {oh[2:0], osc_clk_i};
            end
        end
        ctl_rd(rsa_pkg::CTL_STAT);
        check(d[rsa_pkg::STAT_HALT], 1);
        $display("halt output test done");
        tf[0] = 7'($urandom_range(2, 6));
        tf[1] = -7'($urandom_range(2, 6));
        tf[2] = {1'($urandom()), 5'h00, 1'($urandom())};
        foreach (tf[i])
            trim_case(tf[i]);
        finish_test();
    end
endmodule : test_rsa_serial_trim
